// >>> rtl/shutoff_pkg.sv
// constants and types shared by the dual axis shut-off logic
package shutoff_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	// delay choices in milliseconds
	localparam int unsigned DLY_0_MS = 0;
	localparam int unsigned DLY_1_MS = 1400;
	localparam int unsigned DLY_2_MS = 2800;
	localparam int unsigned DLY_3_MS = 5600;
	localparam int unsigned DLY_4_MS = 9800;
	localparam int unsigned DLY_5_MS = 30800;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// zero-delay response bound
	localparam int unsigned RESP_MS = 10;
	localparam int unsigned RESP_CYC = RESP_MS * CYC_PER_MS;
	// channel disagreement tolerated before fault
	localparam int unsigned MISMATCH_MS = 5;
	localparam int unsigned MISMATCH_CYC = MISMATCH_MS * CYC_PER_MS;
	localparam int unsigned CNT_W = 32;
	localparam logic [2:0] SEL_W = 3'h3;
	typedef enum logic [2:0] {
		SEL_0S, SEL_1S4, SEL_2S8, SEL_5S6, SEL_9S8, SEL_30S8
	} delay_sel_t;
	typedef enum {
		ST_CUT, ST_RUN, ST_DELAY, ST_FAULT
	} axis_state_t;
endpackage

// >>> rtl/axis_shutoff.sv
// one axis: shut-off state machine, delay timer, mismatch watch
`timescale 1ns/1ps
module axis_shutoff #(
	parameter bit HAS_5S6 = 1'b1,
	parameter logic [31:0] MS_CYC = 32'(shutoff_pkg::CYC_PER_MS),
	parameter logic [31:0] MIS_CYC = 32'(shutoff_pkg::MISMATCH_CYC)
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// synchronised contact inputs, 1 = contact closed; delay_sel_in is not synchronised
	input wire logic sw1_in,
	input wire logic sw2_in,
	input wire logic rel_in,
	input wire logic fb_in,
	input wire logic [2:0] delay_sel_in,
	// outputs: drive_out 1 = contact closed, fault_out and fb_err_out 1 = flagged
	output logic drive_out,
	output logic fault_out,
	output logic fb_err_out
);
	// ***************
	// delay decode
	// ***************
	function automatic logic [31:0] delay_ms(input logic [2:0] s, input bit has56);
		unique case (s)
			3'h0: delay_ms = 32'(shutoff_pkg::DLY_0_MS);
			3'h1: delay_ms = 32'(shutoff_pkg::DLY_1_MS);
			3'h2: delay_ms = 32'(shutoff_pkg::DLY_2_MS);
			3'h3: delay_ms = has56 ? 32'(shutoff_pkg::DLY_3_MS) : 32'h0;
			3'h4: delay_ms = 32'(shutoff_pkg::DLY_4_MS);
			3'h5: delay_ms = 32'(shutoff_pkg::DLY_5_MS);
			default: delay_ms = 32'h0;
		endcase
	endfunction

	shutoff_pkg::axis_state_t st_q, st_d;
	logic [31:0] ms_q, ms_d, div_q, div_d, mis_q, mis_d, lim_q, lim_d;
	logic rel_q, rel_d, drv_q, drv_d;
	logic demand, rel_fall, mis_hit;

	// ***************
	// next state
	// ***************
	always_comb begin
		demand = !sw1_in || !sw2_in;
		rel_fall = rel_q && !rel_in;
		mis_hit = (mis_q >= MIS_CYC);
		st_d = st_q;
		ms_d = ms_q;
		div_d = div_q;
		lim_d = lim_q;
		rel_d = rel_in;
		mis_d = (sw1_in != sw2_in) ? (mis_hit ? mis_q : mis_q + 32'h1) : 32'h0;
		div_d = (div_q >= MS_CYC - 32'h1) ? 32'h0 : div_q + 32'h1;
		unique case (st_q)
			shutoff_pkg::ST_CUT: begin
				if (mis_hit) begin
					st_d = shutoff_pkg::ST_FAULT;
				end else if (!demand && rel_fall) begin
					st_d = shutoff_pkg::ST_RUN;
				end
			end
			shutoff_pkg::ST_RUN: begin
				if (demand) begin
					lim_d = delay_ms(delay_sel_in, HAS_5S6);
					ms_d = 32'h0;
					div_d = 32'h0;
					st_d = (lim_d == 32'h0) ? shutoff_pkg::ST_CUT : shutoff_pkg::ST_DELAY;
				end
			end
			shutoff_pkg::ST_DELAY: begin
				if (mis_hit) begin
					st_d = shutoff_pkg::ST_FAULT;
				end else begin
					if (div_q >= MS_CYC - 32'h1) begin
						ms_d = ms_q + 32'h1;
					end
					if (ms_q >= lim_q) begin
						st_d = shutoff_pkg::ST_CUT;
					end
				end
			end
			shutoff_pkg::ST_FAULT: begin
				// leaves only when channels agree again, both closed, and the release input goes from on to off
				if (mis_q == 32'h0 && !demand && rel_fall) begin
					st_d = shutoff_pkg::ST_RUN;
				end
			end
		endcase
		drv_d = (st_d == shutoff_pkg::ST_RUN) || (st_d == shutoff_pkg::ST_DELAY);
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= shutoff_pkg::ST_CUT;
			ms_q <= 32'h0;
			div_q <= 32'h0;
			mis_q <= 32'h0;
			lim_q <= 32'h0;
			rel_q <= 1'b0;
			drv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ms_q <= ms_d;
			div_q <= div_d;
			mis_q <= mis_d;
			lim_q <= lim_d;
			rel_q <= rel_d;
			drv_q <= drv_d;
		end
	end

	assign drive_out = drv_q;
	assign fault_out = (st_q == shutoff_pkg::ST_FAULT);
	// amplifier must mirror us; flag when it does not
	assign fb_err_out = (fb_in != drv_q);

	// ***************
	// checks
	// ***************
	a_run_needs_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		$rose(drv_q) |-> $past(rel_q) && !$past(rel_in)) else $error("release without falling edge");
	a_level_no_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(st_q == shutoff_pkg::ST_CUT && rel_in && rel_q) |=> !drv_q) else $error("level released axis");
	a_zero_delay_cut: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(st_q == shutoff_pkg::ST_RUN && demand && delay_sel_in == 3'h0) |=> !drv_q)
		else $error("zero delay did not cut");
	a_demand_blocks_run: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(st_q == shutoff_pkg::ST_CUT && demand) |=> !drv_q) else $error("ran under demand");
	a_fault_cuts: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(st_q == shutoff_pkg::ST_FAULT) |-> !drv_q) else $error("fault but driving");
	a_delay_holds: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(st_q == shutoff_pkg::ST_DELAY && ms_q < lim_q && !mis_hit) |=> drv_q)
		else $error("delay cut early");
endmodule

// >>> rtl/dual_axis_torque_shutoff.sv
// top: two independent axes with input synchronisers and output mirroring
// Notes on behaviour
// - each axis opens its first shut-off output in the shut-off state and closes it when released.
// - the second shut-off output of an axis always equals the first.
// - both diagnostic outputs of an axis follow the shut-off outputs.
// - an opened switch input demands the shut-off state; closed inputs permit driving.
// - an axis is released only by an on-to-off edge of its release input, never by a level.
// - the two axes are fully independent, each with its own inputs, outputs and state.
// - the shut-off delay is selectable per axis, axis b lacking the 5.6 s choice.
// - with zero delay the outputs open within 10 ms of the switch opening.
`timescale 1ns/1ps
module dual_axis_torque_shutoff (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	// switch, release and feedback pins per axis, [0]=a [1]=b, 1 = closed
	input wire logic [1:0] switch_in_ch1,
	input wire logic [1:0] switch_in_ch2,
	input wire logic [1:0] release_request_in,
	input wire logic [1:0] drive_state_feedback,
	// delay selection per axis
	input wire logic [2:0] delay_sel_a_in,
	input wire logic [2:0] delay_sel_b_in,
	// contacts to amplifier and diagnostics, 1 = closed
	output logic [1:0] shutoff_out_ch1,
	output logic [1:0] shutoff_out_ch2,
	output logic [1:0] diag_out_ch1,
	output logic [1:0] diag_out_ch2,
	// status
	output logic [1:0] torque_cut_state_out,
	output logic [1:0] fault_out,
	output logic [1:0] feedback_err_out
);
	// ***************
	// pin synchronisers
	// ***************
	// only the second stage is read; two-cycle latency fits the 10 ms budget
	logic [7:0] meta_q, sync_q;
	logic [7:0] pins;
	assign pins = {drive_state_feedback, release_request_in, switch_in_ch2, switch_in_ch1};
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= 8'h00;
			sync_q <= 8'h00;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
		end
	end

	logic [5:0] sel_bus;
	logic [1:0] drv;
	assign sel_bus = {delay_sel_b_in, delay_sel_a_in};

	// ***************
	// axes
	// ***************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_axis
			axis_shutoff #(
				.HAS_5S6(g == 0)
			) u_axis (
				.sys_clk_in(sys_clk_in),
				.nrst_in(nrst_in),
				.sw1_in(sync_q[g]),
				.sw2_in(sync_q[2 + g]),
				.rel_in(sync_q[4 + g]),
				.fb_in(sync_q[6 + g]),
				.delay_sel_in(sel_bus[3*g +: 3]),
				.drive_out(drv[g]),
				.fault_out(fault_out[g]),
				.fb_err_out(feedback_err_out[g])
			);
		end
	endgenerate

	// ***************
	// outputs
	// ***************
	assign shutoff_out_ch1 = drv;
	assign shutoff_out_ch2 = drv;
	assign diag_out_ch1 = drv;
	assign diag_out_ch2 = drv;
	assign torque_cut_state_out = ~drv;

	a_channels_equal: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		shutoff_out_ch1 == shutoff_out_ch2) else $error("channels differ");
	a_diag_mirror: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		diag_out_ch1 == shutoff_out_ch1 && diag_out_ch2 == shutoff_out_ch1)
		else $error("diagnostics differ");
	a_pin_cut_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		(!switch_in_ch1[0] && delay_sel_a_in == 3'h0)[*4] |-> !shutoff_out_ch1[0])
		else $error("axis a not cut");
endmodule

// >>> dv/far_side_model.sv
// model of the safety switches and the driven amplifier for both axes
`timescale 1ns/1ps
module far_side_model (
	// clock
	input wire logic sys_clk_in,
	// bench controls, [0]=a [1]=b
	input wire logic [1:0] demand_in,
	input wire logic [1:0] skew_in,
	// contacts from the device
	input wire logic [1:0] cut1_in,
	input wire logic [1:0] cut2_in,
	// contacts to the device, 1 = closed
	output logic [1:0] sw1_out,
	output logic [1:0] sw2_out,
	output logic [1:0] fb_out
);
	// ****************
	// switches
	// ****************
	// skew breaks channel agreement only when a scenario asks for it
	assign sw1_out = ~demand_in;
	assign sw2_out = ~(demand_in | skew_in);
	// ****************
	// amplifier
	// ****************
	// one cycle late, like a real amplifier answering after its own input stage
	always_ff @(posedge sys_clk_in) begin
		fb_out <= cut1_in & cut2_in;
	end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the dual axis shut-off block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] demand = 2'h0, skew = 2'h0, rel = 2'h0, sw1, sw2, fb;
	logic [2:0] sel_a = 3'h0, sel_b = 3'h0;
	logic [1:0] cut1, cut2, dg1, dg2, tcs, flt, fberr;
	int n_fail = 0, cmp_count = 0, cyc = 0, n;
	dual_axis_torque_shutoff i_dut (.sys_clk_in(clk), .nrst_in(nrst),
		.switch_in_ch1(sw1), .switch_in_ch2(sw2), .release_request_in(rel),
		.drive_state_feedback(fb), .delay_sel_a_in(sel_a), .delay_sel_b_in(sel_b),
		.shutoff_out_ch1(cut1), .shutoff_out_ch2(cut2), .diag_out_ch1(dg1),
		.diag_out_ch2(dg2), .torque_cut_state_out(tcs), .fault_out(flt),
		.feedback_err_out(fberr));
	far_side_model i_far (.sys_clk_in(clk), .demand_in(demand), .skew_in(skew),
		.cut1_in(cut1), .cut2_in(cut2), .sw1_out(sw1), .sw2_out(sw2), .fb_out(fb));
	// ****************
	// helpers
	// ****************
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic outs(input logic [1:0] exp);
		chk("shutoff ch1", cut1, exp);
		chk("shutoff ch2", cut2, exp);
		chk("diag ch1", dg1, exp);
		chk("diag ch2", dg2, exp);
		chk("cut state", tcs, ~exp);
	endtask
	task automatic pulse_rel(input logic [1:0] m);
		rel = m;
		repeat (4) @(negedge clk);
		rel = 2'h0;
		repeat (6) @(negedge clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_release();
		outs(2'h0);
		chk("fault after reset", flt, 2'h0);
		rel = 2'h1;
		repeat (20) @(negedge clk);
		outs(2'h0);
		rel = 2'h0;
		repeat (6) @(negedge clk);
		outs(2'h1);
		pulse_rel(2'h2);
		outs(2'h3);
		chk("feedback err", fberr, 2'h0);
	endtask
	task automatic t_cut();
		sel_b = 3'h3;
		demand = 2'h1;
		for (n = 0; n < shutoff_pkg::RESP_CYC && cut1[0] !== 1'b0; n++) @(negedge clk);
		outs(2'h2);
		// amplifier answer still in flight, so axis a must be flagged
		chk("feedback err lag", fberr, 2'h1);
		demand = 2'h3;
		for (n = 0; n < shutoff_pkg::RESP_CYC && cut1[1] !== 1'b0; n++) @(negedge clk);
		outs(2'h0);
		demand = 2'h0;
		repeat (4) @(negedge clk);
		outs(2'h0);
		pulse_rel(2'h3);
		outs(2'h3);
	endtask
	task automatic t_mismatch();
		skew = 2'h1;
		for (n = 0; n < shutoff_pkg::MISMATCH_CYC + 100 && flt[0] !== 1'b1; n++) @(negedge clk);
		chk("fault", flt, 2'h1);
		outs(2'h2);
		pulse_rel(2'h1);
		outs(2'h2);
		skew = 2'h0;
		repeat (4) @(negedge clk);
		pulse_rel(2'h1);
		chk("fault cleared", flt, 2'h0);
		outs(2'h3);
	endtask
	task automatic t_delay();
		// axis a holds for the long delay, axis b has no such choice
		sel_a = 3'h3;
		demand = 2'h3;
		repeat (200) @(negedge clk);
		outs(2'h1);
		// mid-run reset is the only way out of a long delay in a short run
		nrst = 1'b0;
		@(negedge clk);
		outs(2'h0);
		chk("fault in reset", flt, 2'h0);
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		repeat (2) @(negedge clk);
		outs(2'h0);
		demand = 2'h0;
		pulse_rel(2'h3);
		outs(2'h3);
	endtask
	// ****************
	// main
	// ****************
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_release();
		t_cut();
		t_mismatch();
		t_delay();
		close_out();
	end
endmodule
